// ---- verilog/clksel_ydec_exec.sv ----
/*
 * execution of four single-word instructions: ceramic clock select,
 * rc clock select, accumulator invert and y decrement with skip.
 * assumes instructions arrive one per machine cycle from same-clock fetch logic.
 * assumes the loads come from other instructions of the same core, so an
 * invert or a decrement in the same slot wins over a load.
 * assumes the clock-source outputs feed the oscillator switch outside.
 */
`timescale 1ns/10ps
`default_nettype none
`include "clksel_ydec_cfg.svh"
module clksel_ydec_exec (
   input  wire logic                       clock,
   input  wire logic                       nrst,
   input  wire clksel_ydec_pkg::instr_t    instr,
   input  wire logic                       acc_load,
   input  wire logic [3:0]                 acc_load_val,
   input  wire logic                       y_load,
   input  wire logic [3:0]                 y_load_val,
   input  wire logic                       carry_load,
   input  wire logic                       carry_load_val,
   output clksel_ydec_pkg::core_regs_t     regs,
   output clksel_ydec_pkg::clk_src_t       clk_src,
   output logic                            onchip_osc_stop,
   output logic                            skip_next
);
   import clksel_ydec_pkg::*;

   logic       rst_n;
   logic       exec;
   logic       is_ceramic;
   logic       is_rc;
   logic       is_inv;
   logic       is_dey;
   logic [3:0] y_nxt;
   logic [3:0] acc_r;
   logic [3:0] y_r;
   logic       carry_r;
   clk_src_t   clk_src_r;
   logic       osc_stop_r;
   logic       skip_r;

   reset_sync u_rst (
      .clock     (clock),
      .nrst      (nrst),
      .nrst_sync (rst_n)
   );

   // =========================================================
   // decode
   // a skipped slot raises no strobe; the loads still take effect
   assign exec       = instr.valid && !skip_r;
   assign y_nxt      = y_r - 4'h1;

   // one strobe at most per executed slot
   always_comb begin
      is_ceramic = 1'b0;
      is_rc      = 1'b0;
      is_inv     = 1'b0;
      is_dey     = 1'b0;
      if (exec) begin
         case (instr.word)
            `OPC_CERAMIC_SEL: begin
               is_ceramic = 1'b1;
            end
            `OPC_RC_SEL: begin
               is_rc = 1'b1;
            end
            `OPC_ACC_INVERT: begin
               is_inv = 1'b1;
            end
            `OPC_Y_DECREMENT: begin
               is_dey = 1'b1;
            end
            default: begin
            end
         endcase
      end
   end

   // =========================================================
   // clock source
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         clk_src_r <= clk_src_t'(`CLK_SRC_RESET);
      end else if (is_ceramic) begin
         clk_src_r <= CLK_CERAMIC;
      end else if (is_rc) begin
         clk_src_r <= CLK_RC;
      end
   end

   // sticky: only reset restarts the on-chip oscillator
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         osc_stop_r <= `OSC_STOP_RESET;
      end else if (is_rc) begin
         osc_stop_r <= 1'b1;
      end
   end

   // =========================================================
   // accumulator and carry
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         acc_r <= `ACC_RESET;
      end else if (is_inv) begin
         acc_r <= ~acc_r;
      end else if (acc_load) begin
         acc_r <= acc_load_val;
      end
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         carry_r <= `CARRY_RESET;
      end else if (carry_load && !is_inv) begin
         carry_r <= carry_load_val;
      end
   end

   // =========================================================
   // y register and skip
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         y_r <= `Y_RESET;
      end else if (is_dey) begin
         y_r <= y_nxt;
      end else if (y_load) begin
         y_r <= y_load_val;
      end
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         skip_r <= `SKIP_RESET;
      end else if (instr.valid) begin
         skip_r <= is_dey && (y_nxt == `Y_SKIP_VALUE);
      end
   end

   assign regs            = '{acc: acc_r, y: y_r, carry_flag: carry_r};
   assign clk_src         = clk_src_r;
   assign onchip_osc_stop = osc_stop_r;
   assign skip_next       = skip_r;

   // =========================================================
   // assertions
   ceramic_select_a: assert property (@(posedge clock) disable iff (!rst_n)
      is_ceramic |=> clk_src_r == CLK_CERAMIC)
      else $error("ceramic select not taken");
   rc_select_a: assert property (@(posedge clock) disable iff (!rst_n)
      is_rc |=> clk_src_r == CLK_RC)
      else $error("rc select not taken");
   osc_stop_a: assert property (@(posedge clock) disable iff (!rst_n)
      is_rc |=> osc_stop_r)
      else $error("oscillator not stopped");
   y_dec_a: assert property (@(posedge clock) disable iff (!rst_n)
      is_dey |=> y_r == $past(y_r) - 4'h1)
      else $error("y not decremented");
   y_skip_a: assert property (@(posedge clock) disable iff (!rst_n)
      (is_dey && y_r == 4'h0) |=> skip_r ##1 (!instr.valid || !skip_r || !$past(instr.valid)))
      else $error("skip not raised on wrap");
   no_skip_a: assert property (@(posedge clock) disable iff (!rst_n)
      (is_dey && y_r != 4'h0) |=> !skip_r)
      else $error("spurious skip");
   acc_invert_a: assert property (@(posedge clock) disable iff (!rst_n)
      is_inv |=> acc_r == ~$past(acc_r))
      else $error("accumulator not inverted");
   carry_keep_a: assert property (@(posedge clock) disable iff (!rst_n)
      is_inv |=> $stable(carry_r))
      else $error("carry changed by invert");

   // =========================================================
   // invariants around oscillator stop, clock source, skip and loads
   osc_sticky_a: assert property (@(posedge clock) disable iff (!rst_n)
      osc_stop_r |=> osc_stop_r)
      else $error("oscillator restarted without reset");

   clk_hold_a: assert property (@(posedge clock) disable iff (!rst_n)
      (!is_ceramic && !is_rc) |=> $stable(clk_src_r))
      else $error("clock source changed without select");

   skip_consume_a: assert property (@(posedge clock) disable iff (!rst_n)
      (skip_r && instr.valid) |=> !skip_r)
      else $error("skip not consumed");

   skip_y_hold_a: assert property (@(posedge clock) disable iff (!rst_n)
      (skip_r && instr.valid && !y_load) |=> $stable(y_r))
      else $error("skipped slot changed y");

   skip_acc_hold_a: assert property (@(posedge clock) disable iff (!rst_n)
      (skip_r && instr.valid && !acc_load) |=> $stable(acc_r))
      else $error("skipped slot changed accumulator");

   wrap_skip_a: assert property (@(posedge clock) disable iff (!rst_n)
      is_dey |=> ((y_r == `Y_SKIP_VALUE) == skip_r))
      else $error("skip does not follow wrap");

   acc_load_a: assert property (@(posedge clock) disable iff (!rst_n)
      (acc_load && !is_inv) |=> acc_r == $past(acc_load_val))
      else $error("accumulator load lost");

   y_load_a: assert property (@(posedge clock) disable iff (!rst_n)
      (y_load && !is_dey) |=> y_r == $past(y_load_val))
      else $error("y load lost");

   cover_rc_c: cover property (@(posedge clock) disable iff (!rst_n) is_rc);
   cover_back_c: cover property (@(posedge clock) disable iff (!rst_n) is_rc ##[1:20] is_ceramic);
   cover_skip_c: cover property (@(posedge clock) disable iff (!rst_n) is_dey ##1 skip_r);
   cover_inv_c: cover property (@(posedge clock) disable iff (!rst_n) is_inv);
   cover_plain_c: cover property (@(posedge clock) disable iff (!rst_n)
      (is_dey && y_r != 4'h0) ##1 exec);
endmodule : clksel_ydec_exec
`default_nettype wire

// ---- verilog/clksel_ydec_cfg.svh ----
/*
 * constants for the clock-select / y-decrement / acc-invert executor.
 * assumes 10-bit instruction words and 4-bit data registers.
 */
`ifndef CLKSEL_YDEC_CFG_SVH
`define CLKSEL_YDEC_CFG_SVH
`define OPC_CERAMIC_SEL  10'h29A
`define OPC_RC_SEL       10'h29B
`define OPC_ACC_INVERT   10'h01C
`define OPC_Y_DECREMENT  10'h017
`define Y_SKIP_VALUE     4'hF
`define ACC_RESET        4'h0
`define Y_RESET          4'h0
`define CLK_SRC_RESET    2'h0
`define OSC_STOP_RESET   1'h0
`define CARRY_RESET      1'h0
`define SKIP_RESET       1'h0
`endif

// ---- verilog/clksel_ydec_pkg.sv ----
/*
 * types shared by the executor files.
 * assumes the cfg header is in the include path.
 */
`default_nettype none
package clksel_ydec_pkg;
   typedef enum logic [1:0] {
      CLK_CERAMIC = 2'b00,
      CLK_RC      = 2'b01
   } clk_src_t;

   typedef struct packed {
      logic       valid;
      logic [9:0] word;
   } instr_t;

   typedef struct packed {
      logic [3:0] acc;
      logic [3:0] y;
      logic       carry_flag;
   } core_regs_t;
endpackage : clksel_ydec_pkg
`default_nettype wire

// ---- verilog/reset_sync.sv ----
/*
 * two-flop reset release synchroniser.
 * assumes nrst is asynchronous and active low.
 */
`timescale 1ns/10ps
`default_nettype none
module reset_sync (
   input  wire logic clock,
   input  wire logic nrst,
   output logic      nrst_sync
);
   logic meta_r;

   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         meta_r    <= 1'b0;
         nrst_sync <= 1'b0;
      end else begin
         meta_r    <= 1'b1;
         nrst_sync <= meta_r;
      end
   end
endmodule : reset_sync
`default_nettype wire

// ---- tb/tb_clksel_ydec_exec.sv ----
/* bench for clksel_ydec_exec: drives instructions and loads, checks regs,
   clock source, oscillator stop and skip. assumes cfg header on include path. */
`timescale 1ns/10ps
`default_nettype none
`include "clksel_ydec_cfg.svh"
module tb_clksel_ydec_exec;
   import clksel_ydec_pkg::*;
   // ==========
   // stimulus and dut
   logic       clock = 1'b0;
   logic       nrst = 1'b0;
   instr_t     instr = '0;
   logic       acc_load = 1'b0;
   logic [3:0] acc_load_val = 4'h0;
   logic       y_load = 1'b0;
   logic [3:0] y_load_val = 4'h0;
   logic       carry_load = 1'b0;
   logic       carry_load_val = 1'b0;
   core_regs_t regs;
   clk_src_t   clk_src;
   logic       onchip_osc_stop;
   logic       skip_next;
   int         n_errors = 0;
   int         cmp_count = 0;
   always #5 clock = ~clock;
   clksel_ydec_exec uut (.clock(clock), .nrst(nrst), .instr(instr),
      .acc_load(acc_load), .acc_load_val(acc_load_val), .y_load(y_load),
      .y_load_val(y_load_val), .carry_load(carry_load),
      .carry_load_val(carry_load_val), .regs(regs), .clk_src(clk_src),
      .onchip_osc_stop(onchip_osc_stop), .skip_next(skip_next));
   // ==========
   // helpers
   task automatic chk(input logic [3:0] got, input logic [3:0] exp);
      cmp_count++;
      if (got !== exp) begin
         n_errors++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic chk_bit(input logic got, input logic exp);
      cmp_count++;
      if (got !== exp) begin
         n_errors++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk_bit
   task automatic chk_src(input clk_src_t got, input clk_src_t exp);
      cmp_count++;
      if (got !== exp) begin
         n_errors++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk_src
   task automatic put(input logic [9:0] w);
      @(posedge clock);
      instr <= '{valid: 1'b1, word: w};
   endtask : put
   task automatic idle();
      @(posedge clock);
      instr <= '0;
      @(posedge clock);
      #1;
   endtask : idle
   task automatic load(input logic [3:0] a, input logic [3:0] y, input logic c);
      @(posedge clock);
      {acc_load, y_load, carry_load} <= 3'b111;
      acc_load_val <= a;
      y_load_val <= y;
      carry_load_val <= c;
      @(posedge clock);
      {acc_load, y_load, carry_load} <= 3'b000;
      #1;
   endtask : load
   task automatic conclude();
      if (n_errors == 0 && cmp_count > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask : conclude
   // ==========
   // scenarios
   task automatic t_reset();
      chk(regs.acc, `ACC_RESET);
      chk(regs.y, `Y_RESET);
      chk_bit(regs.carry_flag, `CARRY_RESET);
      chk_bit(onchip_osc_stop, `OSC_STOP_RESET);
      chk_bit(skip_next, `SKIP_RESET);
      chk_src(clk_src, clk_src_t'(`CLK_SRC_RESET));
   endtask : t_reset
   task automatic t_invert();
      load(4'h5, 4'h3, 1'b1);
      put(`OPC_ACC_INVERT);
      idle();
      chk(regs.acc, 4'hA);
      chk_bit(regs.carry_flag, 1'b1);
      chk(regs.y, 4'h3);
   endtask : t_invert
   task automatic t_dey();
      load(4'h0, 4'h1, 1'b0);
      put(`OPC_Y_DECREMENT);
      put(`OPC_ACC_INVERT);
      idle();
      chk(regs.y, 4'h0);
      chk(regs.acc, 4'hF);
      chk_bit(skip_next, 1'b0);
      put(`OPC_Y_DECREMENT);
      put(`OPC_Y_DECREMENT);
      #1;
      chk_bit(skip_next, 1'b1);
      put(`OPC_ACC_INVERT);
      idle();
      chk(regs.y, 4'hF);
      chk(regs.acc, 4'h0);
      chk_bit(skip_next, 1'b0);
   endtask : t_dey
   task automatic t_clk();
      put(`OPC_RC_SEL);
      idle();
      chk_src(clk_src, CLK_RC);
      chk_bit(onchip_osc_stop, 1'b1);
      put(`OPC_CERAMIC_SEL);
      idle();
      chk_src(clk_src, CLK_CERAMIC);
      chk_bit(onchip_osc_stop, 1'b1);
   endtask : t_clk
   task automatic t_rerst();
      put(`OPC_RC_SEL);
      idle();
      @(posedge clock);
      nrst <= 1'b0;
      repeat (4) @(posedge clock);
      nrst <= 1'b1;
      repeat (4) @(posedge clock);
      #1;
      chk_src(clk_src, CLK_CERAMIC);
      chk_bit(onchip_osc_stop, `OSC_STOP_RESET);
      chk(regs.y, `Y_RESET);
      put(`OPC_Y_DECREMENT);
      idle();
      chk(regs.y, 4'hF);
      chk_bit(skip_next, 1'b1);
   endtask : t_rerst
   initial begin
      repeat (4) @(posedge clock);
      nrst <= 1'b1;
      repeat (4) @(posedge clock);
      #1;
      t_reset();
      t_invert();
      t_dey();
      t_clk();
      t_rerst();
      conclude();
   end
   initial begin
      #20000;
      n_errors++;
      conclude();
   end
endmodule : tb_clksel_ydec_exec
`default_nettype wire
